// >>> rtl/dmcs_top.sv
// development-mode configuration start-up: port steering, request pin, done gate
`include "dmcs_defines.svh"

module dmcs_top #(
    parameter int SETUP_TIMEOUT_CYCLES = `DMCS_SETUP_TIME_MS * `DMCS_CLK_KHZ
) (
    // clock, enable, reset
    input wire logic clock,
    input wire logic clk_en,
    input wire logic resetn,
    // mode straps
    input wire logic cfg_mode_pin_hi,
    input wire logic cfg_mode_pin_lo,
    // power state machine
    input wire logic state_off,
    input wire logic on_event,
    output logic start_powerup,
    output logic setup_timeout,
    output logic regs_clear,
    output logic supply_immediate,
    // decoded register access from the two-wire engine
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_from_secondary,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    // two-wire engine side of the pin steering
    input wire logic engine_sda_low,
    output logic engine_sda_in,
    output logic engine_scl_in,
    output logic use_secondary,
    output logic [6:0] primary_slave_addr,
    // primary pins
    input wire logic primary_data_pin_i,
    input wire logic primary_clock_pin_i,
    output logic primary_data_pin_o,
    output logic primary_data_pin_oe,
    // secondary pins
    input wire logic secondary_data_pin_i,
    input wire logic secondary_clock_pin_i,
    output logic secondary_data_pin_o,
    output logic secondary_data_pin_oe,
    // configuration request pin
    output logic config_request_out,
    output logic config_request_oe
);

    // ============================================================
    // elaboration checks
    if (SETUP_TIMEOUT_CYCLES < 2)
    begin : g_bad_limit
        $error("SETUP_TIMEOUT_CYCLES must be at least 2");
    end

    // ============================================================
    // helpers
    // primary address from the two-bit select code
    function automatic logic [6:0] pri_addr_of(input logic [1:0] sel);
        unique case (sel)
            2'h0: pri_addr_of = `DMCS_PRI_ADDR_0;
            2'h1: pri_addr_of = `DMCS_PRI_ADDR_1;
            2'h2: pri_addr_of = `DMCS_PRI_ADDR_2;
            2'h3: pri_addr_of = `DMCS_PRI_ADDR_3;
        endcase
    endfunction : pri_addr_of

    // development mode is both strap pins low
    function automatic logic is_dev(input logic [1:0] m);
        is_dev = (m == `DMCS_MODE_DEV);
    endfunction : is_dev

    localparam logic [31:0] LIMIT_LAST = 32'(SETUP_TIMEOUT_CYCLES - 1);

    dmcs_pkg::dmcs_regs_t q, d;
    logic dev;
    logic enter_off;
    logic port_ok;
    logic hit;

    assign dev = is_dev(q.mode);
    assign enter_off = state_off && !q.prev_off;
    // only the port currently steered to the engine may touch the register
    assign port_ok = q.use_sec ? reg_from_secondary : !reg_from_secondary;
    assign hit = (reg_addr == `DMCS_IFCTL_OFFSET);

    // ============================================================
    // next state
    always_comb
    begin
        d = q;
        d.start_pulse = 1'b0;
        d.timeout_pulse = 1'b0;
        d.clear_pulse = 1'b0;
        d.rvalid = 1'b0;
        d.prev_off = state_off;
        // straps are tied, so sampling them while OFF is enough
        if (state_off)
        begin
            d.mode = {cfg_mode_pin_hi, cfg_mode_pin_lo};
        end
        // register writes, accepted in any power state
        if (reg_wr_en && hit && port_ok)
        begin
            d.port_sel = reg_wdata[`DMCS_PORT_SEL_BIT];
            if (dev && reg_from_secondary)
            begin
                d.addr_sel = reg_wdata[`DMCS_ADDR_SEL_HI:`DMCS_ADDR_SEL_LO];
            end
            d.cfg_done = reg_wdata[`DMCS_CFG_DONE_BIT];
            d.reload = reg_wdata[`DMCS_RELOAD_BIT];
        end
        // register reads: unmapped offsets read as zero
        if (reg_rd_en && port_ok)
        begin
            d.rvalid = 1'b1;
            d.rdata = '0;
            if (hit)
            begin
                d.rdata[`DMCS_PORT_SEL_BIT] = q.port_sel;
                d.rdata[`DMCS_ADDR_SEL_HI:`DMCS_ADDR_SEL_LO] = q.addr_sel;
                d.rdata[`DMCS_CFG_DONE_BIT] = q.cfg_done;
                d.rdata[`DMCS_RELOAD_BIT] = q.reload;
                d.rdata[`DMCS_MODE_HI:`DMCS_MODE_LO] = q.mode;
            end
        end
        // start-up sequence
        unique case (q.state)
            dmcs_pkg::S_OFF:
            begin
                if (on_event)
                begin
                    if (!is_dev(d.mode) || (q.first_up && !q.reload))
                    begin
                        d.start_pulse = 1'b1;
                        d.first_up = 1'b1;
                        d.state = dmcs_pkg::S_UP;
                    end
                    else
                    begin
                        d.req_out = 1'b1;
                        d.timer = '0;
                        d.state = dmcs_pkg::S_WAIT;
                    end
                end
            end
            dmcs_pkg::S_WAIT:
            begin
                if (q.cfg_done && dev)
                begin
                    d.start_pulse = 1'b1;
                    d.first_up = 1'b1;
                    d.state = dmcs_pkg::S_UP;
                end
                else if (q.timer == LIMIT_LAST)
                begin
                    d.timeout_pulse = 1'b1;
                    d.state = dmcs_pkg::S_OFF;
                end
                else
                begin
                    d.timer = q.timer + 32'h0000_0001;
                end
            end
            dmcs_pkg::S_UP:
            begin
                d.state = dmcs_pkg::S_UP;
            end
        endcase
        // entering OFF wins over the state chosen above, and over register writes when reload is set
        if (enter_off)
        begin
            d.state = dmcs_pkg::S_OFF;
            if (q.reload)
            begin
                d.port_sel = `DMCS_PORT_SEL_RST;
                d.addr_sel = `DMCS_ADDR_SEL_RST;
                d.cfg_done = `DMCS_CFG_DONE_RST;
                d.reload = `DMCS_RELOAD_RST;
                d.clear_pulse = 1'b1;
            end
            if (q.reload || !q.first_up)
            begin
                d.req_out = 1'b0;
            end
        end
        // supplies enabled once ACTIVE skip slot sequencing
        d.immediate_en = (d.state == dmcs_pkg::S_UP);
        d.req_oe = is_dev(d.mode);
        // custom modes ignore both select fields
        d.use_sec = is_dev(d.mode) && d.port_sel;
        d.pri_addr = is_dev(d.mode) ? pri_addr_of(d.addr_sel) : `DMCS_PRI_ADDR_0;
        // pin steering; registered to keep outputs glitch free
        d.sda_to_engine = q.use_sec ? secondary_data_pin_i : primary_data_pin_i;
        d.scl_to_engine = q.use_sec ? secondary_clock_pin_i : primary_clock_pin_i;
        d.pri_sda_oe = !q.use_sec && engine_sda_low;
        d.sec_sda_oe = q.use_sec && engine_sda_low;
    end

    // ============================================================
    // state register
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            q <= '0;
            q.state <= dmcs_pkg::S_OFF;
            q.mode <= `DMCS_MODE_DEV;
            q.prev_off <= 1'b1;
            q.port_sel <= `DMCS_PORT_SEL_RST;
            q.addr_sel <= `DMCS_ADDR_SEL_RST;
            q.cfg_done <= `DMCS_CFG_DONE_RST;
            q.reload <= `DMCS_RELOAD_RST;
            q.req_oe <= 1'b1;
            q.use_sec <= 1'b1;
            q.pri_addr <= `DMCS_PRI_ADDR_0;
            q.sda_to_engine <= 1'b1;
            q.scl_to_engine <= 1'b1;
        end
        else if (clk_en)
        begin
            q <= d;
        end
    end

    // ============================================================
    // outputs, all straight from the state register
    assign start_powerup = q.start_pulse;
    assign setup_timeout = q.timeout_pulse;
    assign regs_clear = q.clear_pulse;
    assign supply_immediate = q.immediate_en;
    assign reg_rdata = q.rdata;
    assign reg_rvalid = q.rvalid;
    assign engine_sda_in = q.sda_to_engine;
    assign engine_scl_in = q.scl_to_engine;
    assign use_secondary = q.use_sec; // engine answers here at its fixed address
    assign primary_slave_addr = q.pri_addr;
    assign primary_data_pin_o = q.pin_low;
    assign primary_data_pin_oe = q.pri_sda_oe;
    assign secondary_data_pin_o = q.pin_low;
    assign secondary_data_pin_oe = q.sec_sda_oe;
    assign config_request_out = q.req_out;
    assign config_request_oe = q.req_oe;

    // ============================================================
    // assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    a_custom_no_sec: assert property (
        !dev |-> !q.use_sec && q.pri_addr == `DMCS_PRI_ADDR_0)
        else $error("custom mode uses secondary port or moved address");
    a_pri_addr_map: assert property (
        dev && q.addr_sel == 2'h3 |-> q.pri_addr == `DMCS_PRI_ADDR_3)
        else $error("primary address code 3 not mapped");
    a_timeout_off: assert property (
        clk_en && q.state == dmcs_pkg::S_WAIT && !q.cfg_done && q.timer == LIMIT_LAST
        && !enter_off |=> q.timeout_pulse && q.state == dmcs_pkg::S_OFF)
        else $error("set-up time-out did not return to OFF");
    a_done_starts: assert property (
        clk_en && q.state == dmcs_pkg::S_WAIT && q.cfg_done && dev && !enter_off
        |=> q.start_pulse ##1 !q.start_pulse || !clk_en)
        else $error("done flag did not start power-up");
    // straps are live while OFF, so judge the mode the way the next-state logic does
    a_req_rises: assert property (
        clk_en && q.state == dmcs_pkg::S_OFF && on_event && !enter_off && q.reload
        && is_dev(state_off ? {cfg_mode_pin_hi, cfg_mode_pin_lo} : q.mode)
        |=> q.req_out && q.state == dmcs_pkg::S_WAIT)
        else $error("request not raised on start");
    a_req_drops: assert property (
        clk_en && enter_off && q.reload
        |=> !q.req_out && q.clear_pulse && q.port_sel && !q.cfg_done)
        else $error("OFF entry did not drop request and reset registers");
    a_keep_regs: assert property (
        clk_en && enter_off && !q.reload && q.first_up && !reg_wr_en
        |=> q.req_out && $stable(q.addr_sel) && !q.clear_pulse)
        else $error("retention lost registers or request");
    a_start_immed: assert property (q.start_pulse |-> q.immediate_en)
        else $error("supplies not immediate after start");
    a_read_answer: assert property (clk_en && reg_rd_en && port_ok |=> q.rvalid)
        else $error("register read not answered");
    a_sec_steer: assert property (
        clk_en && q.use_sec |=> q.sda_to_engine == $past(secondary_data_pin_i))
        else $error("secondary data not steered to engine");

    c_dev_start: cover property (q.state == dmcs_pkg::S_WAIT ##[1:50] q.start_pulse);
    c_timeout: cover property (q.timeout_pulse);
    c_port_swap: cover property (q.use_sec ##[1:50] !q.use_sec);
    c_retained: cover property (!q.reload && enter_off);

endmodule : dmcs_top

// >>> rtl/dmcs_defines.svh
// constants for the development-mode configuration start-up block
`ifndef DMCS_DEFINES_SVH
`define DMCS_DEFINES_SVH

// ============================================================
// register map
`define DMCS_IFCTL_OFFSET 8'h06
`define DMCS_PORT_SEL_BIT 15
`define DMCS_ADDR_SEL_HI 14
`define DMCS_ADDR_SEL_LO 13
`define DMCS_CFG_DONE_BIT 12
`define DMCS_RELOAD_BIT 11
`define DMCS_MODE_HI 1
`define DMCS_MODE_LO 0

// ============================================================
// reset values
`define DMCS_PORT_SEL_RST 1'h1
`define DMCS_ADDR_SEL_RST 2'h0
`define DMCS_CFG_DONE_RST 1'h0
`define DMCS_RELOAD_RST 1'h1
`define DMCS_MODE_DEV 2'h0

// ============================================================
// slave addresses, seven bit
`define DMCS_SEC_ADDR 7'h34
`define DMCS_PRI_ADDR_0 7'h34
`define DMCS_PRI_ADDR_1 7'h36
`define DMCS_PRI_ADDR_2 7'h3C
`define DMCS_PRI_ADDR_3 7'h3E

// ============================================================
// timing
`define DMCS_SETUP_TIME_MS 100
`define DMCS_CLK_KHZ 20000

`endif

// >>> rtl/dmcs_pkg.sv
// types shared by the development-mode configuration start-up block
package dmcs_pkg;

    // ============================================================
    // start-up sequence states
    typedef enum logic [2:0]
    {
        S_OFF = 3'b001,
        S_WAIT = 3'b010,
        S_UP = 3'b100
    } dmcs_state_t;

    // ============================================================
    // whole state of the block
    typedef struct packed
    {
        dmcs_state_t state;
        logic [1:0] mode;
        logic prev_off;
        logic port_sel;
        logic [1:0] addr_sel;
        logic cfg_done;
        logic reload;
        logic first_up;
        logic req_out;
        logic req_oe;
        logic [31:0] timer;
        logic start_pulse;
        logic timeout_pulse;
        logic clear_pulse;
        logic immediate_en;
        logic [15:0] rdata;
        logic rvalid;
        logic use_sec;
        logic [6:0] pri_addr;
        logic sda_to_engine;
        logic scl_to_engine;
        logic pri_sda_oe;
        logic sec_sda_oe;
        logic pin_low;
    } dmcs_regs_t;

endpackage : dmcs_pkg

// >>> bench/dmcs_cfg_model.sv
// partner model: configuring microcontroller that answers the request pin
module dmcs_cfg_model (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // behaviour chosen by the bench
    input wire logic active,
    input wire logic [7:0] delay,
    input wire logic [15:0] word,
    // request pin from the device
    input wire logic config_request_out,
    // register write towards the engine side, always on the secondary port
    output logic wr_en,
    output logic [7:0] addr,
    output logic [15:0] wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic prev_q;
    // ============================================================
    // wait for the request edge, pause, then one final write
    initial
    begin
        wr_en = 1'h0;
        addr = 8'hff;
        wdata = 16'hffff;
        prev_q = 1'h0;
        forever
        begin
            @(posedge clock);
            if (resetn && active && config_request_out && !prev_q)
            begin
                repeat (delay) @(posedge clock); // supply pacing is the configurer's job
                wr_en <= 1'h1;
                addr <= 8'h06;
                wdata <= word;
                @(posedge clock);
                wr_en <= 1'h0;
                // released lines show the inverse, not a stale value
                addr <= 8'hf9;
                wdata <= ~word;
            end
            prev_q = config_request_out;
        end
    end
endmodule : dmcs_cfg_model

// >>> bench/tb.sv
// self-checking bench for the development-mode configuration start-up block
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int T = 20;
    logic clock, resetn, pin_hi, pin_lo, state_off, on_event, sda_low;
    logic t_wr, t_rd, t_sec, pri_drv, pri_clk, sec_drv, sec_clk, m_act, m_wr, ce;
    logic [7:0] t_addr, m_addr, m_delay;
    logic [15:0] t_wdata, m_word, m_wdata, got, reg_rdata;
    logic gv, start_powerup, setup_timeout, regs_clear, supply_immediate, reg_rvalid;
    logic engine_sda_in, engine_scl_in, use_secondary, pdo, pdoe, sdo, sdoe, req, req_oe;
    logic [6:0] primary_slave_addr;
    logic [6:0] pa [4] = '{7'h34, 7'h36, 7'h3c, 7'h3e};
    int errors, tests_run, cycles, n, b;
    int cnt [3];
    // ============================================================
    // clock, pulse counters and hang guard
    initial
    begin
        clock = 1'h0;
        forever #25 clock = ~clock;
    end
    always @(posedge clock)
    begin
        cnt[0] += int'(start_powerup === 1'b1);
        cnt[1] += int'(setup_timeout === 1'b1);
        cnt[2] += int'(regs_clear === 1'b1);
        cycles++;
        if (cycles == 5000)
        begin
            errors++;
            report_and_stop();
        end
    end
    // ============================================================
    // device and partner; pins are open drain with pull-ups
    dmcs_top #(.SETUP_TIMEOUT_CYCLES(T)) dut (.clock(clock), .clk_en(ce), .resetn(resetn),
        .cfg_mode_pin_hi(pin_hi), .cfg_mode_pin_lo(pin_lo), .state_off(state_off),
        .on_event(on_event), .start_powerup(start_powerup), .setup_timeout(setup_timeout),
        .regs_clear(regs_clear), .supply_immediate(supply_immediate), .reg_wr_en(t_wr | m_wr),
        .reg_rd_en(t_rd), .reg_addr(m_wr ? m_addr : t_addr),
        .reg_wdata(m_wr ? m_wdata : t_wdata), .reg_from_secondary(t_sec | m_wr),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .engine_sda_low(sda_low),
        .engine_sda_in(engine_sda_in), .engine_scl_in(engine_scl_in),
        .use_secondary(use_secondary), .primary_slave_addr(primary_slave_addr),
        .primary_data_pin_i(pri_drv & ~pdoe), .primary_clock_pin_i(pri_clk),
        .primary_data_pin_o(pdo), .primary_data_pin_oe(pdoe),
        .secondary_data_pin_i(sec_drv & ~sdoe), .secondary_clock_pin_i(sec_clk),
        .secondary_data_pin_o(sdo), .secondary_data_pin_oe(sdoe),
        .config_request_out(req), .config_request_oe(req_oe));
    dmcs_cfg_model partner (.clock(clock), .resetn(resetn), .active(m_act), .delay(m_delay),
        .word(m_word), .config_request_out(req), .wr_en(m_wr), .addr(m_addr), .wdata(m_wdata));
    // ============================================================
    // shared tasks
    task chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e)
        begin
            errors++;
            $display("BAD %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task tick(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask : tick
    // one register access; read answer sampled right after the taking edge
    task acc(input logic wr, input logic sec, input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        t_wr <= wr;
        t_rd <= !wr;
        t_sec <= sec;
        t_addr <= a;
        t_wdata <= d;
        @(posedge clock);
        t_wr <= 1'h0;
        t_rd <= 1'h0;
        t_addr <= ~a;
        t_wdata <= ~d;
        #1;
        gv = reg_rvalid;
        got = reg_rdata;
    endtask : acc
    task power_on;
        @(posedge clock);
        on_event <= 1'h1;
        @(posedge clock);
        on_event <= 1'h0;
        state_off <= 1'h0;
        #1;
    endtask : power_on
    task off_entry;
        b = cnt[2];
        @(posedge clock);
        state_off <= 1'h1;
        tick(3);
    endtask : off_entry
    // bounded wait for a pulse counter to move past its base
    task wait_cnt(input int w, input int base, input int lim);
        n = 0;
        while (cnt[w] == base && n <= lim)
        begin
            tick(1);
            n++;
        end
    endtask : wait_cnt
    task report_and_stop;
        if (errors == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop
    // ============================================================
    // main sequence
    initial
    begin
        {resetn, pin_hi, pin_lo, on_event, sda_low, t_wr, t_rd, t_sec, m_act} = 9'h000;
        {state_off, pri_drv, pri_clk, sec_drv, sec_clk} = 5'h1f;
        ce = 1'h1;
        {t_addr, t_wdata, m_delay, m_word} = {8'h00, 16'h0000, 8'h05, 16'h9800};
        repeat (8) @(posedge clock);
        resetn <= 1'h1;
        acc(0, 1, 8'h06, 0);
        chk(got, 16'h8800);
        chk({use_secondary, primary_slave_addr, req, req_oe}, {1'b1, 7'h34, 2'b01});
        acc(0, 0, 8'h06, 0);
        chk(gv, 0);
        acc(0, 1, 8'h40, 0);
        chk({gv, got}, {1'b1, 16'h0000});
        @(posedge clock);
        sec_drv <= 1'h0;
        sec_clk <= 1'h0;
        sda_low <= 1'h1;
        tick(2);
        chk({engine_sda_in, engine_scl_in, sdoe, pdoe, pdo, sdo}, 6'h08);
        // enable low: new pin levels must not reach the engine
        @(posedge clock);
        ce <= 1'h0;
        sda_low <= 1'h0;
        sec_drv <= 1'h1;
        sec_clk <= 1'h1;
        tick(2);
        chk({engine_scl_in, sdoe}, 2'b01);
        @(posedge clock);
        ce <= 1'h1;
        for (int i = 0; i < 4; i++)
        begin
            acc(1, 1, 8'h06, {1'b1, i[1:0], 13'h0800});
            tick(2);
            chk(primary_slave_addr, pa[i]);
        end
        // slow configurer finishes the start-up
        @(posedge clock);
        m_act <= 1'h1;
        b = cnt[0];
        power_on();
        chk(req, 1);
        wait_cnt(0, b, 12);
        chk(n inside {[5:10]}, 1);
        chk(supply_immediate, 1);
        off_entry();
        chk(cnt[2] - b, 1);
        chk(req, 0);
        acc(0, 1, 8'h06, 0);
        chk(got, 16'h8800);
        // nobody answers the request
        @(posedge clock);
        m_act <= 1'h0;
        b = cnt[1];
        power_on();
        chk(req, 1);
        wait_cnt(1, b, T + 3);
        chk(n inside {[T:T + 2]}, 1);
        off_entry();
        // switch to the primary pins and back
        acc(1, 1, 8'h06, 16'h0800);
        @(posedge clock);
        pri_drv <= 1'h0;
        tick(2);
        chk({use_secondary, engine_sda_in}, 2'h0);
        acc(1, 0, 8'h06, 16'h6800);
        acc(0, 0, 8'h06, 0);
        chk({got & 16'he800, primary_slave_addr}, {16'h0800, 7'h34});
        @(posedge clock);
        pri_drv <= 1'h1;
        acc(1, 0, 8'h06, 16'h8800);
        // retention: prompt configurer clears reload as it finishes
        acc(1, 1, 8'h06, 16'h8800);
        @(posedge clock);
        {m_act, m_delay, m_word} <= {1'b1, 8'h00, 16'h9000};
        b = cnt[0];
        power_on();
        wait_cnt(0, b, 8);
        chk(n <= 8, 1);
        @(posedge clock);
        m_act <= 1'h0;
        off_entry();
        chk(cnt[2] - b, 0);
        chk(req, 1);
        acc(0, 1, 8'h06, 0);
        chk(got & 16'he800, 16'h8000);
        b = cnt[0];
        power_on();
        wait_cnt(0, b, 3);
        chk(n <= 3, 1);
        // every custom mode from a fresh reset
        for (int m = 1; m < 4; m++)
        begin
            @(posedge clock);
            resetn <= 1'h0;
            {pin_hi, pin_lo} <= m[1:0];
            state_off <= 1'h1;
            @(posedge clock);
            resetn <= 1'h1;
            tick(2);
            chk({use_secondary, req_oe}, 2'h0);
            acc(0, 0, 8'h06, 0);
            chk(got & 16'h0803, 16'h0800 | m);
            acc(0, 1, 8'h06, 0);
            chk(gv, 0);
            b = cnt[0];
            power_on();
            wait_cnt(0, b, 3);
            chk(n <= 3, 1);
        end
        report_and_stop();
    end
endmodule : tb
